// ### src/adc_mux_control.sv
// Control top: registers, power gating, routing and result formatting
//
// Contract
// - Converter, track-and-hold and amplifier powered only while enable bit is one.
// - Enable bit zero keeps the whole converter subsystem in low power shutdown.
// - Nine-input multiplexer feeds a 10-bit converter with track-and-hold and window.
// - After reset every multiplexer input is single-ended, no pairing active.
// - Three-bit gain field in configuration register selects amplifier gain.
// - Reset sets the amplifier gain selection to unity.
// - Enabled even port pins share one input, odd pins another, wired-OR.
// - High-voltage amplifier output is selectable like any other channel.
// - Pairing register bits 7 to 4 read zero and ignore writes.
// - Bit 3 pairs port even positive and odd negative when set.
// - Bit 2 gives high-voltage channel result in two's complement when set.
// - Bit 1 pairs inputs 2 positive and 3 negative when set.
// - Bit 0 pairs inputs 0 positive and 1 negative when set.
// - Differential channels deliver data in two's complement; single-ended unchanged.
// - Four-bit channel code selects inputs, amplifier, ground, port groups, temperature.
// - Each port pin select bit connects its pin to the multiplexer.
// - Differential high-voltage channel puts its reference on the negative input.
`timescale 1ns/10ps
`include "adc_mux_regs.svh"
module adc_mux_control #(
  parameter int RESULT_WIDTH = 10
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rdata,
  input  wire logic                     conv_start,
  input  wire logic                     raw_valid,
  input  wire logic [RESULT_WIDTH-1:0]  raw_result,
  output logic                          power_enable,
  output logic      [2:0]               gain_select_field,
  output logic      [3:0]               mux_pos_select,
  output logic                          neg_to_partner,
  output logic                          neg_to_highvolt_reference_input,
  output logic      [7:0]               port_pin_enable,
  output logic                          even_group_active,
  output logic                          odd_group_active,
  output logic                          result_valid,
  output logic      [RESULT_WIDTH-1:0]  result_data
);
  if (RESULT_WIDTH != 10) begin : g_width_check
    $error("Converter result width must be 10");
  end

  logic [7:0]              conv_control_reg;
  logic [7:0]              conv_config_reg;
  logic [7:0]              channel_select_reg;
  logic [7:0]              input_pair_config;
  logic [7:0]              port_pin_select_reg;
  logic [7:0]              next_conv_control_reg;
  logic [7:0]              next_conv_config_reg;
  logic [7:0]              next_channel_select_reg;
  logic [7:0]              next_input_pair_config;
  logic [7:0]              next_port_pin_select_reg;
  logic [7:0]              next_reg_rdata;
  logic [3:0]              latched_code;
  logic [3:0]              latched_pair;
  logic [3:0]              next_latched_code;
  logic [3:0]              next_latched_pair;
  logic                    next_power_enable;
  logic [2:0]              next_gain;
  logic [3:0]              next_pos;
  logic                    next_neg_partner;
  logic                    next_neg_highvolt_reference_input;
  logic [7:0]              next_port_pin_enable;
  logic                    next_even_active;
  logic                    next_odd_active;
  logic                    next_result_valid;
  logic [RESULT_WIDTH-1:0] next_result_data;

  mux_route_if rt ();
  assign rt.channel_code = latched_code;
  assign rt.pair_config  = latched_pair;

  mux_route_decode u_decode (
    .rt (rt)
  );

  // Register file
  always_comb begin
    next_conv_control_reg    = conv_control_reg;
    next_conv_config_reg     = conv_config_reg;
    next_channel_select_reg  = channel_select_reg;
    next_input_pair_config   = input_pair_config;
    next_port_pin_select_reg = port_pin_select_reg;
    next_reg_rdata           = reg_rdata;
    if (reg_write) begin
      unique case (reg_addr)
        `ADDR_CONV_CONTROL:   next_conv_control_reg = reg_wdata;
        `ADDR_CONV_CONFIG:    next_conv_config_reg = reg_wdata;
        `ADDR_CHANNEL_SELECT: next_channel_select_reg = reg_wdata & `CHAN_CODE_MASK;
        `ADDR_INPUT_PAIR:     next_input_pair_config = reg_wdata & `PAIR_CFG_MASK;
        `ADDR_PORT_PIN_SEL:   next_port_pin_select_reg = reg_wdata;
        default:              next_reg_rdata = reg_rdata;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        `ADDR_CONV_CONTROL:   next_reg_rdata = conv_control_reg;
        `ADDR_CONV_CONFIG:    next_reg_rdata = conv_config_reg;
        `ADDR_CHANNEL_SELECT: next_reg_rdata = channel_select_reg;
        `ADDR_INPUT_PAIR:     next_reg_rdata = input_pair_config;
        `ADDR_PORT_PIN_SEL:   next_reg_rdata = port_pin_select_reg;
        default:              next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      conv_control_reg    <= `RST_CONV_CONTROL;
      conv_config_reg     <= `RST_CONV_CONFIG;
      channel_select_reg  <= `RST_CHANNEL_SELECT;
      input_pair_config   <= `RST_INPUT_PAIR;
      port_pin_select_reg <= `RST_PORT_PIN_SEL;
      reg_rdata           <= 8'h00;
    end else begin
      conv_control_reg    <= next_conv_control_reg;
      conv_config_reg     <= next_conv_config_reg;
      channel_select_reg  <= next_channel_select_reg;
      input_pair_config   <= next_input_pair_config;
      port_pin_select_reg <= next_port_pin_select_reg;
      reg_rdata           <= next_reg_rdata;
    end
  end

  // Routing is frozen at conversion start so mid-conversion writes cannot glitch the mux
  always_comb begin
    next_latched_code = latched_code;
    next_latched_pair = latched_pair;
    if (conv_start && power_enable) begin
      next_latched_code = channel_select_reg[3:0];
      next_latched_pair = input_pair_config[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      latched_code <= 4'h0;
      latched_pair <= 4'h0;
    end else begin
      latched_code <= next_latched_code;
      latched_pair <= next_latched_pair;
    end
  end

  // Analog controls and result formatting
  always_comb begin
    next_power_enable    = conv_control_reg[`CTRL_ENABLE_BIT];
    next_gain            = conv_config_reg[`CFG_GAIN_LSB +: 3];
    next_pos             = 4'(rt.route.pos);
    next_neg_partner     = rt.route.neg_is_partner;
    next_neg_highvolt_reference_input       = rt.route.neg_is_highvolt_reference_input;
    next_port_pin_enable = port_pin_select_reg;
    next_even_active     = |{port_pin_select_reg[6], port_pin_select_reg[4],
                             port_pin_select_reg[2], port_pin_select_reg[0]};
    next_odd_active      = |{port_pin_select_reg[7], port_pin_select_reg[5],
                             port_pin_select_reg[3], port_pin_select_reg[1]};
    next_result_valid    = 1'b0;
    next_result_data     = result_data;
    if (!conv_control_reg[`CTRL_ENABLE_BIT]) begin
      next_gain            = `GAIN_UNITY;
      next_port_pin_enable = 8'h00;
      next_even_active     = 1'b0;
      next_odd_active      = 1'b0;
    end
    // Converter stays powered until power_enable drops, so results follow that level
    if (raw_valid && power_enable) begin
      next_result_valid = 1'b1;
      if (rt.route.differential) begin
        // Offset binary to two's complement: flip the sign bit
        next_result_data = raw_result ^ {1'b1, {(RESULT_WIDTH-1){1'b0}}};
      end else begin
        next_result_data = raw_result;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      power_enable      <= 1'b0;
      gain_select_field <= `GAIN_UNITY;
      mux_pos_select    <= 4'h0;
      neg_to_partner    <= 1'b0;
      neg_to_highvolt_reference_input      <= 1'b0;
      port_pin_enable   <= 8'h00;
      even_group_active <= 1'b0;
      odd_group_active  <= 1'b0;
      result_valid      <= 1'b0;
      result_data       <= '0;
    end else begin
      power_enable      <= next_power_enable;
      gain_select_field <= next_gain;
      mux_pos_select    <= next_pos;
      neg_to_partner    <= next_neg_partner;
      neg_to_highvolt_reference_input      <= next_neg_highvolt_reference_input;
      port_pin_enable   <= next_port_pin_enable;
      even_group_active <= next_even_active;
      odd_group_active  <= next_odd_active;
      result_valid      <= next_result_valid;
      result_data       <= next_result_data;
    end
  end
endmodule

// ### src/adc_mux_pkg.sv
// Types shared by the converter front end modules
package adc_mux_pkg;
  typedef enum logic [3:0] {
    src_in0, src_in1, src_in2, src_in3, src_highvolt, src_ground,
    src_port_even, src_port_odd, src_temp
  } mux_source_t;
  typedef struct packed {
    mux_source_t pos;
    logic        neg_is_partner;
    logic        neg_is_highvolt_reference_input;
    logic        differential;
  } route_t;
endpackage

// ### src/adc_mux_regs.svh
// Register offsets, field positions and reset values of the converter front end
`ifndef ADC_MUX_REGS_SVH
`define ADC_MUX_REGS_SVH
`define ADDR_CONV_CONTROL   8'he8
`define ADDR_CONV_CONFIG    8'hbc
`define ADDR_CHANNEL_SELECT 8'hbb
`define ADDR_INPUT_PAIR     8'hba
`define ADDR_PORT_PIN_SEL   8'hbd
`define CTRL_ENABLE_BIT     7
`define CFG_GAIN_LSB        0
`define GAIN_UNITY          3'h0
`define RST_CONV_CONTROL    8'h00
`define RST_CONV_CONFIG     8'h00
`define RST_CHANNEL_SELECT  8'h00
`define RST_INPUT_PAIR      8'h00
`define RST_PORT_PIN_SEL    8'h00
`define PAIR_CFG_MASK       8'h0f
`define CHAN_CODE_MASK      8'h0f
`define PAIR_PORT_BIT       3
`define PAIR_HV_BIT         2
`define PAIR_IN23_BIT       1
`define PAIR_IN01_BIT       0
`endif

// ### src/mux_route_decode.sv
// Combinational channel and pairing decoder
`timescale 1ns/10ps
`include "adc_mux_regs.svh"
module mux_route_decode (
  mux_route_if.decoder rt
);
  always_comb begin
    rt.route = '{pos: adc_mux_pkg::src_temp, neg_is_partner: 1'b0,
                 neg_is_highvolt_reference_input: 1'b0, differential: 1'b0};
    if (rt.channel_code[3]) begin
      rt.route.pos = adc_mux_pkg::src_temp;
    end else begin
      unique case (rt.channel_code[2:0])
        3'h0, 3'h1: begin
          if (rt.pair_config[`PAIR_IN01_BIT]) begin
            rt.route.pos = adc_mux_pkg::src_in0;
            rt.route.neg_is_partner = 1'b1;
            rt.route.differential = 1'b1;
          end else begin
            rt.route.pos = rt.channel_code[0] ? adc_mux_pkg::src_in1 : adc_mux_pkg::src_in0;
          end
        end
        3'h2, 3'h3: begin
          if (rt.pair_config[`PAIR_IN23_BIT]) begin
            rt.route.pos = adc_mux_pkg::src_in2;
            rt.route.neg_is_partner = 1'b1;
            rt.route.differential = 1'b1;
          end else begin
            rt.route.pos = rt.channel_code[0] ? adc_mux_pkg::src_in3 : adc_mux_pkg::src_in2;
          end
        end
        3'h4, 3'h5: begin
          if (rt.pair_config[`PAIR_HV_BIT]) begin
            rt.route.pos = adc_mux_pkg::src_highvolt;
            rt.route.neg_is_highvolt_reference_input = 1'b1;
            rt.route.differential = 1'b1;
          end else begin
            rt.route.pos = rt.channel_code[0] ? adc_mux_pkg::src_ground
                                              : adc_mux_pkg::src_highvolt;
          end
        end
        default: begin
          if (rt.pair_config[`PAIR_PORT_BIT]) begin
            rt.route.pos = adc_mux_pkg::src_port_even;
            rt.route.neg_is_partner = 1'b1;
            rt.route.differential = 1'b1;
          end else begin
            rt.route.pos = rt.channel_code[0] ? adc_mux_pkg::src_port_odd
                                              : adc_mux_pkg::src_port_even;
          end
        end
      endcase
    end
  end
endmodule

// ### src/mux_route_if.sv
// Routing result passed from the decoder to the control top
`timescale 1ns/10ps
interface mux_route_if;
  logic [3:0]           channel_code;
  logic [3:0]           pair_config;
  adc_mux_pkg::route_t  route;
  modport decoder (input channel_code, input pair_config, output route);
  modport user    (output channel_code, output pair_config, input route);
endinterface

// ### verification/adc_mux_checker.sv
// Port assertions for the converter front end control
`timescale 1ns/10ps
`include "adc_mux_regs.svh"
module adc_mux_checker #(
  parameter int RESULT_WIDTH = 10
) (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic                    reg_write,
  input wire logic                    reg_read,
  input wire logic [7:0]              reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic [7:0]              reg_rdata,
  input wire logic                    conv_start,
  input wire logic                    raw_valid,
  input wire logic [RESULT_WIDTH-1:0] raw_result,
  input wire logic                    power_enable,
  input wire logic [2:0]              gain_select_field,
  input wire logic [3:0]              mux_pos_select,
  input wire logic                    neg_to_partner,
  input wire logic                    neg_to_highvolt_reference_input,
  input wire logic [7:0]              port_pin_enable,
  input wire logic                    even_group_active,
  input wire logic                    odd_group_active,
  input wire logic                    result_valid,
  input wire logic [RESULT_WIDTH-1:0] result_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_power_write: assert property (reg_write && reg_addr == `ADDR_CONV_CONTROL
    |-> ##2 power_enable == $past(reg_wdata[`CTRL_ENABLE_BIT], 2)) else $error("enable lost");
  // Two disabled cycles, so a gain or pin register lagging by one edge is tolerated
  chk_off_quiet: assert property (!power_enable && $past(!power_enable)
    |-> gain_select_field == `GAIN_UNITY && port_pin_enable == 8'h00
    && !even_group_active && !odd_group_active) else $error("active while disabled");
  chk_group_or: assert property ($stable(port_pin_enable)
    |-> even_group_active == |(port_pin_enable & 8'h55)
    && odd_group_active == |(port_pin_enable & 8'haa)) else $error("group wrong");
  chk_result_time: assert property (raw_valid && power_enable |=> result_valid)
    else $error("result late");
  chk_result_cause: assert property (result_valid |-> $past(raw_valid && power_enable))
    else $error("stray result");
  chk_result_fmt: assert property (result_valid |-> result_data == ($past(raw_result)
    ^ {$past(neg_to_partner | neg_to_highvolt_reference_input), {(RESULT_WIDTH-1){1'h0}}}))
    else $error("result format wrong");
  chk_route_hold: assert property ($changed({mux_pos_select, neg_to_partner, neg_to_highvolt_reference_input})
    |-> $past(conv_start, 2)) else $error("route moved without start");
  chk_pair_zero: assert property (reg_read && reg_addr == `ADDR_INPUT_PAIR
    |=> reg_rdata[7:4] == 4'h0) else $error("pair upper bits set");
  cover property (result_valid && neg_to_partner);
  cover property (result_valid && neg_to_highvolt_reference_input);
  cover property (even_group_active && odd_group_active);
endmodule
bind adc_mux_control adc_mux_checker #(.RESULT_WIDTH(RESULT_WIDTH)) adc_mux_checker_i (
  .clk, .nrst, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .conv_start,
  .raw_valid, .raw_result, .power_enable, .gain_select_field, .mux_pos_select,
  .neg_to_partner, .neg_to_highvolt_reference_input, .port_pin_enable, .even_group_active,
  .odd_group_active, .result_valid, .result_data);

// ### verification/adc_mux_control_test.sv
// Self-checking bench for the converter front end control
`timescale 1ns/10ps
`include "adc_mux_regs.svh"
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module adc_mux_control_test;
  logic        clk, nrst, reg_write, reg_read, conv_start, raw_valid, rd_seen;
  logic        power_enable, neg_to_partner, neg_to_highvolt_reference_input, result_valid;
  logic        even_group_active, odd_group_active;
  logic [2:0]  gain_select_field;
  logic [3:0]  mux_pos_select;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, port_pin_enable, pr, ch, pn;
  logic [9:0]  raw_result, result_data, rw;
  logic [15:0] ev;
  logic [15:0] rq[$];
  logic [15:0] cq[$];
  logic [7:0]  ad[6] = '{`ADDR_CONV_CONTROL, `ADDR_CONV_CONFIG, `ADDR_CHANNEL_SELECT,
                         `ADDR_INPUT_PAIR, `ADDR_PORT_PIN_SEL, 8'h00};
  integer      seed, num_errors, tests_run, i;
  adc_mux_control #(.RESULT_WIDTH(10)) adc_mux_control_i (.clk, .nrst, .reg_write,
    .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .conv_start, .raw_valid, .raw_result,
    .power_enable, .gain_select_field, .mux_pos_select, .neg_to_partner, .neg_to_highvolt_reference_input,
    .port_pin_enable, .even_group_active, .odd_group_active, .result_valid, .result_data);
  wire [20:0]  outs = {power_enable, gain_select_field, mux_pos_select, neg_to_partner,
                       neg_to_highvolt_reference_input, port_pin_enable, even_group_active, odd_group_active,
                       result_valid};
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_write <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_read <= 1; reg_addr <= a; rq.push_back({8'h00, e});
    @(posedge clk);
    reg_read <= 0;
  endtask
  // Odd partner of an active pair converts through the even code
  function logic [5:0] rt(input logic [3:0] c, input logic [3:0] p);
    logic [3:0] s;
    s = c[3] ? 4'h8 : c;
    if ((s == 1 && p[0]) || (s == 3 && p[1]) || (s == 5 && p[2]) || (s == 7 && p[3])) begin
      s = s - 4'h1;
    end
    rt = {s, (s == 0 && p[0]) || (s == 2 && p[1]) || (s == 6 && p[3]), s == 4 && p[2]};
  endfunction
  task conv(input logic [3:0] c, input logic [3:0] p, input logic [9:0] r);
    logic [5:0] e;
    e = rt(c, p);
    @(posedge clk); conv_start <= 1;
    @(posedge clk); conv_start <= 0;
    wr(`ADDR_INPUT_PAIR, {4'h0, ~p});
    @(posedge clk); raw_valid <= 1; raw_result <= r;
    cq.push_back({e, r ^ {e[1] | e[0], 9'h0}});
    @(posedge clk); raw_valid <= 0;
  endtask
  always @(posedge clk) begin
    rd_seen <= reg_read;
    if (rd_seen === 1'h1) begin
      ev = rq.pop_front();
      `CHK("reg_rdata", ev[7:0], reg_rdata)
    end
    if (result_valid === 1'h1) begin
      if (cq.size() == 0) `CHK("result_valid", 1'h0, result_valid)
      else begin
        ev = cq.pop_front();
        `CHK("route", ev, {outs[16:11], result_data})
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test;
  end
  initial begin
    seed = 2; num_errors = 0; tests_run = 0; nrst = 0; rd_seen = 0;
    reg_write = 0; reg_read = 0; reg_addr = 8'h00; reg_wdata = 8'h00;
    conv_start = 0; raw_valid = 0; raw_result = 10'h000;
    repeat (2) @(posedge clk);
    nrst <= 1;
    `CHK("reset", 21'h0, outs)
    for (i = 0; i < 6; i++) rd(ad[i], 8'h00);
    wr(`ADDR_CONV_CONTROL, 8'h80);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    #1 `CHK("power_enable", 1'h1, power_enable)
    for (i = 0; i < 8; i++) begin
      wr(`ADDR_CONV_CONFIG, i[7:0]);
      @(posedge clk);
      #1 `CHK("gain", i[2:0], gain_select_field)
    end
    for (i = 0; i < 6; i++) begin
      pn = 8'($random(seed));
      wr(`ADDR_PORT_PIN_SEL, pn);
      @(posedge clk);
      #1 `CHK("pins", {pn, |(pn & 8'h55), |(pn & 8'haa)}, outs[10:1])
      rd(`ADDR_PORT_PIN_SEL, pn);
    end
    // Every channel code against every pairing configuration
    for (i = 0; i < 256; i++) begin
      ch = {4'($random(seed)), i[3:0]};
      pr = {4'($random(seed)), i[7:4]};
      rw = 10'($random(seed));
      wr(`ADDR_INPUT_PAIR, pr);
      wr(`ADDR_CHANNEL_SELECT, ch);
      rd(`ADDR_INPUT_PAIR, pr & `PAIR_CFG_MASK);
      rd(`ADDR_CHANNEL_SELECT, ch & `CHAN_CODE_MASK);
      conv(ch[3:0], pr[3:0], rw);
    end
    wr(`ADDR_PORT_PIN_SEL, 8'hff);
    wr(`ADDR_CONV_CONTROL, 8'h00);
    @(posedge clk); conv_start <= 1; raw_valid <= 1;
    @(posedge clk); conv_start <= 0; raw_valid <= 0;
    #1 `CHK("shutdown", 14'h0, {outs[20:17], outs[10:1]})
    for (i = 0; i < 20 && cq.size() + rq.size() > 0; i++) @(posedge clk);
    `CHK("pending", 0, cq.size() + rq.size())
    stop_test;
  end
endmodule
